// file: rtl/adcs_top.sv
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module adcs_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic cmp_in,
  output logic [9:0] dac_code,
  output logic [3:0] chan_sel,
  output logic sample_en,
  output logic irq
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic on_reg;
  logic go_reg;
  logic [3:0] chan_reg;
  logic [2:0] acq_sel_reg;
  logic [2:0] clk_sel_reg;
  logic fmt_reg;
  logic [2:0] clk_run_reg;
  logic [7:0] res_hi_reg;
  logic [7:0] res_lo_reg;
  logic status_reg;
  logic mask_reg;
  logic [4:0] acq_cnt_reg;
  adcs_pkg::adcs_state_e state_reg;
  adcs_pkg::adcs_state_e state_next;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  logic sample_en_reg;
  logic irq_reg;
  logic [3:0] chan_out_reg;

  // ------------------------------------------------------------------
  // converter interface, declared ahead of every use
  // ------------------------------------------------------------------
  adcs_conv_if conv ();

  // ------------------------------------------------------------------
  // bus slave: zero wait states, always okay
  // ------------------------------------------------------------------
  logic addr_ok;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic wr_ctrl;
  logic wr_timing;
  logic wr_status;
  logic wr_mask;
  logic wr_res_hi;
  logic wr_res_lo;
  logic [31:0] rd_mux;

  // only the low address byte is decoded and hsize is not looked at:
  // every register is one aligned word
  assign addr_ok = hsel && hready && htrans[1];
  assign wr_ctrl = wr_pend_reg && (wr_addr_reg == adcs_pkg::ADDR_CTRL);
  assign wr_timing = wr_pend_reg && (wr_addr_reg == adcs_pkg::ADDR_TIMING);
  assign wr_status = wr_pend_reg && (wr_addr_reg == adcs_pkg::ADDR_STATUS);
  assign wr_mask = wr_pend_reg && (wr_addr_reg == adcs_pkg::ADDR_MASK);
  assign wr_res_hi = wr_pend_reg && (wr_addr_reg == adcs_pkg::ADDR_RES_HI);
  assign wr_res_lo = wr_pend_reg && (wr_addr_reg == adcs_pkg::ADDR_RES_LO);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      adcs_pkg::ADDR_CTRL: begin
        // only the start bit shows activity; the phase stays hidden
        rd_mux[adcs_pkg::CTRL_ON_BIT] = on_reg;
        rd_mux[adcs_pkg::CTRL_GO_BIT] = go_reg; // R6
        rd_mux[adcs_pkg::CTRL_CHAN_LSB +: 4] = chan_reg;
      end
      adcs_pkg::ADDR_TIMING: begin
        rd_mux[adcs_pkg::TIMING_CLK_LSB +: 3] = clk_sel_reg;
        rd_mux[adcs_pkg::TIMING_ACQ_LSB +: 3] = acq_sel_reg;
        rd_mux[adcs_pkg::TIMING_FMT_BIT] = fmt_reg;
      end
      adcs_pkg::ADDR_RES_HI: rd_mux[7:0] = res_hi_reg;
      adcs_pkg::ADDR_RES_LO: rd_mux[7:0] = res_lo_reg;
      adcs_pkg::ADDR_STATUS: rd_mux[adcs_pkg::STAT_DONE_BIT] = status_reg;
      adcs_pkg::ADDR_MASK: rd_mux[adcs_pkg::STAT_DONE_BIT] = mask_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data is sampled in the address phase; the master never overlaps
  // a write data phase with a following address phase, so it is never stale
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'b0;
      hresp_reg <= 1'b0;
    end else begin
      // low only in reset, so no access is taken before the slave is up
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      wr_pend_reg <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_reg <= haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------------
  // start and abort decode
  // ------------------------------------------------------------------
  logic start_req;
  logic abort_req;
  logic done_evt;
  logic [4:0] acq_len;

  assign done_evt = conv.done;
  assign acq_len = adcs_pkg::acq_periods(acq_sel_reg); // R1 R15
  // start only from rest and only when the converter was already on
  assign start_req = wr_ctrl && hwdata[adcs_pkg::CTRL_GO_BIT] && on_reg &&
                     (state_reg == adcs_pkg::ST_IDLE);
  // clearing start or switching off while busy discards the conversion
  assign abort_req = wr_ctrl && (state_reg != adcs_pkg::ST_IDLE) &&
                     (!hwdata[adcs_pkg::CTRL_GO_BIT] || !hwdata[adcs_pkg::CTRL_ON_BIT]);

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adcs_pkg::ST_IDLE: begin
        if (start_req) begin
          if (acq_len == 5'd0) begin
            state_next = adcs_pkg::ST_CONV; // R3
          end else begin
            state_next = adcs_pkg::ST_ACQ; // R2
          end
        end
      end
      adcs_pkg::ST_ACQ: begin
        // an abort outranks the tick, so a late clear never starts a conversion
        if (abort_req) begin
          state_next = adcs_pkg::ST_IDLE;
        end else if (conv.tick && acq_cnt_reg == 5'd1) begin
          state_next = adcs_pkg::ST_CONV; // R2
        end
      end
      adcs_pkg::ST_CONV: begin
        if (abort_req || done_evt) begin
          state_next = adcs_pkg::ST_IDLE; // R5
        end
      end
      default: state_next = adcs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= adcs_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // acquisition counter, reloaded on every fresh start
  // a zero length never enters the acquisition state, so zero is never counted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_cnt_reg <= 5'd0;
    end else if (start_req) begin
      acq_cnt_reg <= acq_len; // R18
    end else if (state_reg == adcs_pkg::ST_ACQ && conv.tick) begin
      acq_cnt_reg <= 5'(acq_cnt_reg - 5'd1); // R18
    end
  end

  // clock choice is frozen for the run so a rewrite cannot stretch it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_run_reg <= adcs_pkg::CLK_SEL_RST;
    end else if (start_req) begin
      clk_run_reg <= clk_sel_reg;
    end
  end

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_reg <= 1'b0;
      chan_reg <= adcs_pkg::CHAN_RST;
    end else if (wr_ctrl) begin
      on_reg <= hwdata[adcs_pkg::CTRL_ON_BIT];
      chan_reg <= hwdata[adcs_pkg::CTRL_CHAN_LSB +: 4];
    end
  end

  // start bit: set by software, held through both phases, cleared at the end
  // a start while busy is ignored, not queued
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      go_reg <= 1'b0;
    end else if (start_req) begin
      go_reg <= 1'b1; // R6
    end else if (done_evt || abort_req) begin
      go_reg <= 1'b0; // R5 R17
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_sel_reg <= adcs_pkg::ACQ_SEL_RST; // R4
      clk_sel_reg <= adcs_pkg::CLK_SEL_RST;
      fmt_reg <= 1'b0;
    end else if (wr_timing) begin
      acq_sel_reg <= hwdata[adcs_pkg::TIMING_ACQ_LSB +: 3];
      clk_sel_reg <= hwdata[adcs_pkg::TIMING_CLK_LSB +: 3];
      fmt_reg <= hwdata[adcs_pkg::TIMING_FMT_BIT];
    end
  end

  // ------------------------------------------------------------------
  // result registers: loaded by a completed conversion or by a software write
  // ------------------------------------------------------------------
  // a completion outranks a software write in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_hi_reg <= adcs_pkg::RES_RST;
      res_lo_reg <= adcs_pkg::RES_RST;
    end else if (done_evt && state_reg == adcs_pkg::ST_CONV) begin
      if (fmt_reg) begin
        res_hi_reg <= {6'h00, conv.result[9:8]}; // R17
        res_lo_reg <= conv.result[7:0]; // R17
      end else begin
        res_hi_reg <= conv.result[9:2]; // R17
        res_lo_reg <= {conv.result[1:0], 6'h00}; // R17
      end
    end else begin
      if (wr_res_hi) begin
        res_hi_reg <= hwdata[7:0];
      end
      if (wr_res_lo) begin
        res_lo_reg <= hwdata[7:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // completion flag, mask, interrupt
  // ------------------------------------------------------------------
  // a completion in the clearing cycle wins, so no event is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= 1'b0;
    end else if (done_evt && state_reg == adcs_pkg::ST_CONV) begin
      status_reg <= 1'b1; // R5 R17
    end else if (wr_status && hwdata[adcs_pkg::STAT_DONE_BIT]) begin
      status_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= 1'b0;
    end else if (wr_mask) begin
      mask_reg <= hwdata[adcs_pkg::STAT_DONE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      // registered, so irq trails the flag by one cycle
      irq_reg <= status_reg && mask_reg;
    end
  end

  // ------------------------------------------------------------------
  // analog side: switch opens in the very edge the conversion begins
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_en_reg <= 1'b0;
      chan_out_reg <= adcs_pkg::CHAN_RST;
    end else begin
      sample_en_reg <= on_reg && (state_next != adcs_pkg::ST_CONV); // R9 R5
      // the pin follows the control write one cycle later
      chan_out_reg <= chan_reg;
    end
  end

  // ------------------------------------------------------------------
  // conversion clock and successive approximation
  // ------------------------------------------------------------------
  assign conv.run = (state_reg != adcs_pkg::ST_IDLE);
  // idle shows the live choice so the first period after a start already
  // uses the new divider; a run keeps the one latched at its start
  assign conv.clk_sel = (state_reg == adcs_pkg::ST_IDLE) ? clk_sel_reg :
                        clk_run_reg; // R8 R16
  assign conv.start = (state_next == adcs_pkg::ST_CONV) && (state_reg != adcs_pkg::ST_CONV);
  assign conv.abort = abort_req;
  assign conv.cmp = cmp_in;

  adcs_tad_gen u_tad_gen (
    .clk(clk),
    .rst_n(rst_n),
    .conv(conv.tadgen)
  );

  adcs_sar u_sar (
    .clk(clk),
    .rst_n(rst_n),
    .conv(conv.sar)
  );

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  // no access can fail, so the response stays okay
  assign hresp = hresp_reg;
  assign dac_code = conv.code;
  assign chan_sel = chan_out_reg;
  assign sample_en = sample_en_reg;
  assign irq = irq_reg;

endmodule
`default_nettype wire

// file: include/adcs_pkg.sv
// Function
// (R1) acquisition duration is programmable from 2 to 20 conversion-clock periods
// (R2) nonzero acquisition: keep sampling that long after start, then convert unaided
// (R3) zero acquisition field: start stops sampling at once and converts immediately
// (R4) acquisition-time field resets to zero, selecting manual acquisition
// (R5) on completion clear start bit, set complete flag, resume sampling
// (R6) no status tells acquisition from conversion; start bit stays set for both
// (R7) every 10-bit conversion takes exactly 11 conversion-clock periods
// (R8) clock select: 000=2,100=4,001=8,101=16,010=32,110=64 oscillator periods, x11=RC
// (R9) sampling switch opens when conversion starts and stays open throughout
// (R10) manual mode: software waits the acquisition time before setting start
// (R11) software picks the shortest conversion period above about 2 us
// (R12) software uses each divider only below its frequency limit
// (R13) with RC clock above 1 MHz the device should sleep during conversion
// (R14) RC conversion clock has a nominal period of about 4 us
// (R15) acquisition field: 001=2,010=4,011=6,100=8,101=12,110=16,111=20 periods
// (R16) RC clock selected: one instruction cycle passes before the clock runs
// (R17) result registers load together with start-bit clear and flag set
// (R18) phases timed by counting conversion-clock periods, reloaded on each new start
package adcs_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_RES_HI = 8'h08;
  localparam logic [7:0] ADDR_RES_LO = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int CTRL_CHAN_LSB = 2;
  localparam int TIMING_CLK_LSB = 0;
  localparam int TIMING_ACQ_LSB = 3;
  localparam int TIMING_FMT_BIT = 7;
  localparam int STAT_DONE_BIT = 0;
  localparam logic [2:0] ACQ_SEL_RST = 3'h0;
  localparam logic [2:0] CLK_SEL_RST = 3'h0;
  localparam logic [3:0] CHAN_RST = 4'h0;
  localparam logic [7:0] RES_RST = 8'h00;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int RC_TAD_NS = 4000;
  localparam logic [7:0] RC_TAD_CYC = 8'(RC_TAD_NS / CLK_PERIOD_NS);
  localparam logic [7:0] TCY_CYC = 8'h04;
  localparam logic [3:0] CONV_LAST_TAD = 4'hA;
  localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;

  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} adcs_state_e;

  function automatic logic is_rc(input logic [2:0] sel);
    return sel[1:0] == 2'b11;
  endfunction

  // conversion clock period in system clock cycles
  function automatic logic [7:0] tad_cycles(input logic [2:0] sel);
    logic [2:0] expo;
    expo = 3'd1 + {2'b00, sel[2]} + {sel[1:0], 1'b0};
    if (is_rc(sel)) begin
      return RC_TAD_CYC;
    end
    return 8'(8'h01 << expo);
  endfunction

  function automatic logic [4:0] acq_periods(input logic [2:0] sel);
    case (sel)
      3'h1: return 5'd2;
      3'h2: return 5'd4;
      3'h3: return 5'd6;
      3'h4: return 5'd8;
      3'h5: return 5'd12;
      3'h6: return 5'd16;
      3'h7: return 5'd20;
      default: return 5'd0;
    endcase
  endfunction

endpackage

// file: include/adcs_conv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adcs_conv_if;
  logic run;
  logic [2:0] clk_sel;
  logic tick;
  logic start;
  logic abort;
  logic cmp;
  logic [9:0] code;
  logic done;
  logic [9:0] result;
  modport seq (output run, clk_sel, start, abort, cmp, input tick, code, done, result);
  modport tadgen (input run, clk_sel, output tick);
  modport sar (input tick, start, abort, cmp, output code, done, result);
endinterface
`default_nettype wire

// file: rtl/adcs_tad_gen.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_tad_gen (
  input wire logic clk,
  input wire logic rst_n,
  adcs_conv_if.tadgen conv
);

  logic [7:0] cnt_reg;
  logic [7:0] period;
  logic [7:0] first_load;

  assign period = adcs_pkg::tad_cycles(conv.clk_sel); // R8 R14
  // the rc source waits one instruction cycle so a sleep can be entered first
  assign first_load = adcs_pkg::is_rc(conv.clk_sel) ?
                      8'(period - 8'h01 + adcs_pkg::TCY_CYC) : 8'(period - 8'h01); // R16
  assign conv.tick = conv.run && (cnt_reg == 8'h00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
    end else if (!conv.run) begin
      cnt_reg <= first_load; // R18
    end else if (cnt_reg == 8'h00) begin
      cnt_reg <= 8'(period - 8'h01);
    end else begin
      cnt_reg <= 8'(cnt_reg - 8'h01);
    end
  end

endmodule
`default_nettype wire

// file: rtl/adcs_sar.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_sar (
  input wire logic clk,
  input wire logic rst_n,
  adcs_conv_if.sar conv
);

  logic [9:0] code_reg;
  logic [9:0] trial_reg;
  logic [3:0] idx_reg;
  logic busy_reg;
  logic done_reg;
  logic [9:0] result_reg;

  assign conv.code = code_reg;
  assign conv.done = done_reg;
  assign conv.result = result_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= 10'h000;
      trial_reg <= 10'h000;
      idx_reg <= 4'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      result_reg <= 10'h000;
    end else begin
      done_reg <= 1'b0;
      if (conv.abort) begin
        busy_reg <= 1'b0;
      end else if (conv.start) begin
        busy_reg <= 1'b1;
        idx_reg <= 4'h0;
        code_reg <= adcs_pkg::SAR_FIRST_TRIAL;
        trial_reg <= adcs_pkg::SAR_FIRST_TRIAL;
      end else if (busy_reg && conv.tick) begin
        // ten decision periods and one period to hand the result over
        if (idx_reg == adcs_pkg::CONV_LAST_TAD) begin // R7
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          result_reg <= code_reg;
        end else begin
          code_reg <= (conv.cmp ? code_reg : (code_reg & ~trial_reg)) | (trial_reg >> 1);
          trial_reg <= trial_reg >> 1;
          idx_reg <= 4'(idx_reg + 4'h1);
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: test/adcs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic cmp_in,
  input wire logic [9:0] dac_code,
  input wire logic [3:0] chan_sel,
  input wire logic sample_en,
  input wire logic irq
);
  logic wr_q;
  logic [7:0] a_q;
  logic [2:0] acq_q;
  logic [3:0] chan_q;
  logic ctrl_wd;
  logic on_q;
  logic se_q;
  logic [10:0] low_cnt;

  // ------------------------------------------------------------------
  // bus snoop: the checker keeps its own copy of the acquisition field, the on bit and the channel
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      a_q <= 8'h00;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
      a_q <= haddr[7:0];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_q <= 3'h0;
    end else if (wr_q && a_q == adcs_pkg::ADDR_TIMING) begin
      acq_q <= hwdata[5:3];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_q <= 4'h0;
      on_q <= 1'b0;
    end else if (ctrl_wd) begin
      chan_q <= hwdata[5:2];
      on_q <= hwdata[0];
    end
  end
  assign ctrl_wd = wr_q && a_q == adcs_pkg::ADDR_CTRL;
  // cycles the switch has stayed open since it opened; switching off is no conversion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      se_q <= 1'b0;
      low_cnt <= 11'h000;
    end else begin
      se_q <= sample_en;
      if (sample_en || !on_q) begin
        low_cnt <= 11'h000;
      end else if ((se_q || low_cnt != 11'h000) && low_cnt != 11'h7FF) begin
        low_cnt <= 11'(low_cnt + 11'h001);
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_manual_start: assert property (
    ctrl_wd && hwdata[1:0] == 2'b11 && acq_q == 3'h0 && sample_en |-> ##[1:8] !sample_en)
    else $error("manual start did not open the sampling switch");
  chk_auto_hold: assert property (
    ctrl_wd && hwdata[1:0] == 2'b11 && acq_q != 3'h0 && sample_en |-> ##1 sample_en[*4])
    else $error("programmed acquisition cut short");
  chk_switch_open: assert property (
    $changed(dac_code) |-> !sample_en || !$past(sample_en))
    else $error("trial code moved while sampling");
  chk_conv_min: assert property (
    $fell(sample_en) && on_q |-> !sample_en[*8] ##1 !sample_en[*8] ##1 !sample_en[*5])
    else $error("conversion shorter than eleven periods");
  chk_conv_max: assert property (
    low_cnt <= 11'h460)
    else $error("conversion never finished");
  chk_sar_first: assert property (
    $fell(sample_en) && on_q |-> ##[0:120] dac_code == 10'h200)
    else $error("first trial code missing");
  chk_chan_follow: assert property (
    ctrl_wd |-> ##2 chan_sel == chan_q)
    else $error("channel select not taken");
  chk_rdata_hold: assert property (
    !$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata))
    else $error("read data changed without a read");

  cover property ($rose(sample_en));
  cover property ($rose(irq));
  cover property (ctrl_wd && hwdata[1:0] == 2'b01 && acq_q != 3'h0);
endmodule

bind adcs_top adcs_assertions u_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cmp_in(cmp_in),
  .dac_code(dac_code), .chan_sel(chan_sel), .sample_en(sample_en), .irq(irq));
`default_nettype wire

// file: test/adcs_analog_src.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_analog_src (
  input wire logic clk,
  input wire logic sample_en,
  input wire logic [9:0] dac_code,
  input wire logic [9:0] vin,
  output logic cmp_in
);
  logic [9:0] held;
  // the capacitor follows the pin only while the switch is closed
  always @(posedge clk) begin
    if (sample_en) begin
      held <= vin;
    end
  end
  // an empty capacitor reads as below every trial code
  assign cmp_in = (held >= dac_code) === 1'b1;
endmodule
`default_nettype wire

// file: test/adcs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_top_tb;
  typedef struct packed {
    logic [2:0] cs;
    logic [2:0] aq;
    logic [7:0] tad;
    logic [4:0] acq;
    logic fmt;
    logic [9:0] vin;
    logic msk;
  } adcs_row_s;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, cmp_in, sample_en, irq;
  logic [31:0] haddr, hwdata, hrdata, q, hold;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [9:0] dac_code, vin;
  logic [3:0] chan_sel;
  logic [15:0] exp_res;
  int error_cnt, tests_run, n1, n2, rc;
  adcs_row_s rows [8] = '{
    '{3'h0, 3'h0, 8'h02, 5'd0, 1'b0, 10'h2A5, 1'b1},
    '{3'h4, 3'h1, 8'h04, 5'd2, 1'b1, 10'h3FF, 1'b0},
    '{3'h1, 3'h2, 8'h08, 5'd4, 1'b0, 10'h000, 1'b1},
    '{3'h5, 3'h3, 8'h10, 5'd6, 1'b1, 10'h155, 1'b0},
    '{3'h2, 3'h4, 8'h20, 5'd8, 1'b0, 10'h200, 1'b1},
    '{3'h6, 3'h5, 8'h40, 5'd12, 1'b1, 10'h1FF, 1'b0},
    // rc rows stand for a part asleep while it converts; the model has no noise
    '{3'h3, 3'h6, 8'h64, 5'd16, 1'b0, 10'h0C3, 1'b1},
    '{3'h7, 3'h7, 8'h64, 5'd20, 1'b1, 10'h301, 1'b0}};

  adcs_top DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cmp_in(cmp_in), .dac_code(dac_code),
    .chan_sel(chan_sel), .sample_en(sample_en), .irq(irq));
  adcs_analog_src u_src (.clk(clk), .sample_en(sample_en), .dac_code(dac_code), .vin(vin),
    .cmp_in(cmp_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  task automatic wait_se(input logic lvl, inout int n);
    while (sample_en !== lvl && n < 5000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    finish_test;
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, vin} = '0;
    hsize = 3'h2;
    rst_n = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rc = rows[i].cs[1:0] == 2'b11 ? 4 : 0;
      bus(1'b1, adcs_pkg::ADDR_MASK, {31'h0, rows[i].msk});
      bus(1'b1, adcs_pkg::ADDR_TIMING, {24'h00_0000, rows[i].fmt, 1'b0, rows[i].aq, rows[i].cs});
      bus(1'b1, adcs_pkg::ADDR_CTRL, {26'h0, i[3:0], 2'b01});
      vin <= rows[i].vin;
      // let the input settle before the start bit is set
      repeat (8) @(posedge clk);
      bus(1'b1, adcs_pkg::ADDR_CTRL, {26'h0, i[3:0], 2'b11});
      n1 = 0;
      wait_se(1'b0, n1);
      vin <= ~rows[i].vin;
      bus(1'b0, adcs_pkg::ADDR_CTRL, 32'h0);
      chk(q[1], 1'b1);
      n2 = 2;
      wait_se(1'b1, n2);
      chk(n1 >= rows[i].acq * rows[i].tad && n1 <= rows[i].acq * rows[i].tad + 6 + rc, 1);
      chk(n2 >= 11 * rows[i].tad && n2 <= 11 * rows[i].tad + 6 + rc, 1);
      repeat (2) @(posedge clk);
      chk(irq, rows[i].msk);
      chk(chan_sel, i[3:0]);
      bus(1'b0, adcs_pkg::ADDR_CTRL, 32'h0);
      chk(q[1], 1'b0);
      bus(1'b0, adcs_pkg::ADDR_STATUS, 32'h0);
      chk(q[0], 1'b1);
      chk(hresp, 1'b0);
      exp_res = rows[i].fmt ? {6'h00, rows[i].vin} : {rows[i].vin, 6'h00};
      bus(1'b0, adcs_pkg::ADDR_RES_HI, 32'h0);
      chk(q[7:0], exp_res[15:8]);
      bus(1'b0, adcs_pkg::ADDR_RES_LO, 32'h0);
      chk(q[7:0], exp_res[7:0]);
      bus(1'b1, adcs_pkg::ADDR_STATUS, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
    end
    // abort during a long acquisition: no flag, result kept
    bus(1'b1, adcs_pkg::ADDR_TIMING, 32'h0000_0038);
    bus(1'b0, adcs_pkg::ADDR_RES_HI, 32'h0);
    hold = q;
    bus(1'b1, adcs_pkg::ADDR_CTRL, 32'h0000_0003);
    bus(1'b0, adcs_pkg::ADDR_CTRL, 32'h0);
    chk(q[1], 1'b1);
    bus(1'b1, adcs_pkg::ADDR_CTRL, 32'h0000_0001);
    repeat (60) @(posedge clk);
    chk(sample_en, 1'b1);
    bus(1'b0, adcs_pkg::ADDR_STATUS, 32'h0);
    chk(q[0], 1'b0);
    bus(1'b0, adcs_pkg::ADDR_RES_HI, 32'h0);
    chk(q, hold);
    // unmapped place reads zero and ignores writes
    bus(1'b1, 8'h18, 32'hFFFF_FFFF);
    bus(1'b0, 8'h18, 32'h0);
    chk(q, 32'h0000_0000);
    // second reset in mid-acquisition
    bus(1'b1, adcs_pkg::ADDR_CTRL, 32'h0000_0003);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, adcs_pkg::ADDR_TIMING, 32'h0);
    chk(q, 32'h0000_0000);
    chk(sample_en, 1'b0);
    chk(irq, 1'b0);
    finish_test;
  end
endmodule
`default_nettype wire
